// ### common/mrfc_pkg.sv
// Shared constants for the motor ramp and fault control core
package mrfc_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 100;
	localparam int INRUSH_BASE_NS     = 5_000_000;  // Code 0000h
	localparam int INRUSH_STEP_NS     = 102_160;    // Per code step
	localparam int OC_DEGLITCH_NS     = 3_000;      // Plain default
	localparam int OC_RETRY_NS        = 1_600_000;  // Plain default
	localparam int INRUSH_BASE_CYC    = INRUSH_BASE_NS / CLK_PERIOD_NS;
	localparam int INRUSH_STEP_CYC    = INRUSH_STEP_NS / CLK_PERIOD_NS;
	localparam int OC_DEGLITCH_CYC    =
		(OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_RETRY_CYC       = OC_RETRY_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_SETPOINT = 8'h04;
	localparam logic [7:0] ADDR_INRUSH   = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;
	localparam logic [7:0] ADDR_CLEAR    = 8'h10;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int CTRL_MODE_LSB   = 0;  // Two bits
	localparam int CTRL_SOFT_BIT   = 2;
	localparam int CTRL_SCALE_LSB  = 3;  // Two bits
	localparam int CTRL_IN_A_BIT   = 5;
	localparam int CTRL_IN_B_BIT   = 6;
	localparam int CTRL_OCSEL_BIT  = 7;  // 1: auto retry
	localparam int CTRL_THSEL_BIT  = 8;  // 1: auto recovery
	localparam int CTRL_OVPEN_BIT  = 9;
	localparam int CLEAR_CMD_BIT   = 0;

	// Status register fields
	localparam int STAT_FAULT_BIT  = 0;
	localparam int STAT_OC_BIT     = 1;
	localparam int STAT_TH_BIT     = 2;
	localparam int STAT_UV_BIT     = 3;
	localparam int STAT_BLANK_BIT  = 4;
	localparam int STAT_LEVEL_LSB  = 8;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] INRUSH_RST   = 16'h260C;  // About 1 s
	localparam logic [7:0]  SETPOINT_RST = 8'h00;
	localparam logic        OVPEN_RST    = 1'b1;

	// Regulation modes with soft ramp
	localparam logic [1:0] MODE_SPEED   = 2'h2;
	localparam logic [1:0] MODE_VOLTAGE = 2'h3;

	// Scale base shift: code 0 multiplies by 16
	localparam logic [3:0] SCALE_BASE_SHIFT = 4'h4;

	// Pin input indices and synchroniser reset pattern
	localparam int PIN_OVER_TEMP  = 4;
	localparam int PIN_VM_LOW     = 5;
	localparam int PIN_OUT_OVER   = 6;
	localparam int PIN_BRAKE_OC   = 7;
	localparam int PIN_SLEEP      = 8;
	localparam int PIN_COUNT      = 9;
	localparam logic [8:0] PIN_SYNC_RST = 9'h020;  // Supply low at reset

	// Ramp sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RAMP_UP,
		ST_RUN,
		ST_RAMP_DOWN
	} mrfc_state_type;

endpackage : mrfc_pkg

// ### src/mrfc_core.sv
// Ramp sequencer, protection logic and APB registers of the motor core
//
// Function
// - Scale codes 0 to 3 multiply by 16, 32, 64 and 128.
// - Target speed equals setpoint times selected scale factor.
// - Soft ramp enable works only in speed or voltage mode.
// - Soft start raises drive gradually over the inrush time.
// - Direction change ramps down to zero, then soft starts reversed.
// - Both bridge inputs zero: soft stop first, then high impedance.
// - Setpoint written zero triggers a soft stop over inrush time.
// - Stall detection blanked for the inrush time after start.
// - Inrush code maps 5 ms at 0000h to 6.7 s at FFFFh.
// - With soft ramp, ramp time is inrush value times setpoint.
// - Current limit beyond deglitch time trips FETs, flags, pin.
// - Auto retry holds FETs off for retry time, then retries.
// - Latch-off holds FETs off until clear command or power cycle.
// - Every high-side and low-side FET has its own detector.
// - Over-temperature disables FETs, sets flags, pulls pin low.
// - Thermal auto recovery clears fault, keeps thermal flag.
// - Thermal latch-off resumes only after clear command.
// - Supply low: outputs off, charge pump off, pin low.
// - Undervoltage sets flags; recovery clears fault, keeps uv flag.
// - Core reset: flags low, pin high; power-up holds fault.
// - Output above supply in sleep or high-Z brakes low sides.
// - Overvoltage brake enabled at reset, kept through sleep.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module mrfc_core
	import mrfc_pkg::*;
#(
	parameter int INRUSH_BASE = INRUSH_BASE_CYC,
	parameter int RETRY_CYC   = OC_RETRY_CYC
) (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  ocLimit,
	input  wire logic        overTemp,
	input  wire logic        vmLow,
	input  wire logic        outOverSupply,
	input  wire logic        brakeOverCur,
	input  wire logic        sleepReq,
	output logic      [7:0]  driveLevel,
	output logic      [14:0] targetSpeed,
	output logic             bridgeEnable,
	output logic             bridgeDir,
	output logic             bridgeHiZ,
	output logic             chargePumpEn,
	output logic      [1:0]  lowSideBrake,
	output logic             stallBlank,
	output logic             faultPinNOut,
	output logic             faultPinNOe
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [PIN_COUNT-1:0] pinRaw;
	logic [PIN_COUNT-1:0] syncA_r;
	logic [PIN_COUNT-1:0] syncB_r;
	logic [PIN_COUNT-1:0] syncC_r;
	logic [PIN_COUNT-1:0] pinFilt_r;
	logic [9:0]           ctrl_r;
	logic [7:0]           setpoint_r;
	logic [15:0]          inrush_r;
	logic                 apbWrite;
	logic                 clrCmd;
	logic [31:0]          statusWord;
	logic [31:0]          rdataNxt;
	logic                 addrOk;
	logic                 softActive;
	logic                 runReq;
	logic                 dirReq;
	logic                 bridgeOff;
	logic [31:0]          stepPeriod;
	logic [31:0]          stepCnt_r;
	logic                 stepTick;
	logic [31:0]          blankCnt_r;
	mrfc_state_type       state_r;
	logic [7:0]           level_r;
	logic                 dir_r;
	logic [7:0]           ocCnt_r;
	logic                 ocAny;
	logic                 ocTrip;
	logic                 ocLatch_r;
	logic [31:0]          retryCnt_r;
	logic                 ocOff;
	logic                 thLatch_r;
	logic                 thOff;
	logic                 powerUp_r;
	logic                 ocFlag_r;
	logic                 thFlag_r;
	logic                 uvFlag_r;
	logic                 faultFlag_r;
	logic                 faultNxt;
	logic                 sleepNow;
	logic                 vmLowNow;
	logic                 tempHigh;
	logic                 hiZNxt;
	logic                 brakeOn;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	assign pinRaw = {sleepReq, brakeOverCur, outOverSupply, vmLow,
		overTemp, ocLimit};

	// Three stages; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : gSync
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					syncA_r[gi]   <= PIN_SYNC_RST[gi];
					syncB_r[gi]   <= PIN_SYNC_RST[gi];
					syncC_r[gi]   <= PIN_SYNC_RST[gi];
					pinFilt_r[gi] <= PIN_SYNC_RST[gi];
				end else begin
					syncA_r[gi] <= pinRaw[gi];
					syncB_r[gi] <= syncA_r[gi];
					syncC_r[gi] <= syncB_r[gi];
					if (syncB_r[gi] == syncC_r[gi]) begin
						pinFilt_r[gi] <= syncC_r[gi];
					end
				end
			end
		end
	endgenerate

	assign sleepNow = pinFilt_r[PIN_SLEEP];
	assign vmLowNow = pinFilt_r[PIN_VM_LOW];
	assign tempHigh = pinFilt_r[PIN_OVER_TEMP];

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// One wait state: pready rises in the second access cycle
	assign apbWrite = psel & penable & pready & pwrite;
	assign clrCmd   = apbWrite & (paddr == ADDR_CLEAR) &
		pwdata[CLEAR_CMD_BIT];

	// Flags and live state for software
	always_comb begin
		statusWord = 32'h0;
		statusWord[STAT_FAULT_BIT] = faultFlag_r;
		statusWord[STAT_OC_BIT]    = ocFlag_r;
		statusWord[STAT_TH_BIT]    = thFlag_r;
		statusWord[STAT_UV_BIT]    = uvFlag_r;
		statusWord[STAT_BLANK_BIT] = stallBlank;
		statusWord[STAT_LEVEL_LSB +: 8] = level_r;
	end

	// Read mux; the clear register reads as zero
	always_comb begin
		addrOk   = 1'b1;
		rdataNxt = 32'h0;
		case (paddr)
			ADDR_CTRL:     rdataNxt = {22'h0, ctrl_r};
			ADDR_SETPOINT: rdataNxt = {24'h0, setpoint_r};
			ADDR_INRUSH:   rdataNxt = {16'h0, inrush_r};
			ADDR_STATUS:   rdataNxt = statusWord;
			ADDR_CLEAR:    rdataNxt = 32'h0;
			default:       addrOk   = 1'b0;
		endcase
	end

	// Handshake and read data, answered one cycle into the access phase
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addrOk;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= rdataNxt;
			end
		end
	end

	// Writable registers; overvoltage enable is never touched by sleep
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r                 <= 10'h0;
			ctrl_r[CTRL_OVPEN_BIT] <= OVPEN_RST;
			setpoint_r             <= SETPOINT_RST;
			inrush_r               <= INRUSH_RST;
		end else if (apbWrite) begin
			case (paddr)
				ADDR_CTRL:     ctrl_r     <= pwdata[9:0];
				ADDR_SETPOINT: setpoint_r <= pwdata[7:0];
				ADDR_INRUSH:   inrush_r   <= pwdata[15:0];
				default:       ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Speed target and ramp timing
	// ------------------------------------------------------------------
	// Shift by 4 plus scale code gives x16, x32, x64, x128
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			targetSpeed <= 15'h0;
		end else begin
			targetSpeed <= 15'({7'h0, setpoint_r} << (SCALE_BASE_SHIFT +
				{2'h0, ctrl_r[CTRL_SCALE_LSB +: 2]}));
		end
	end

	// Soft ramp is honoured only in speed or voltage regulation
	assign softActive = ctrl_r[CTRL_SOFT_BIT] &
		((ctrl_r[1:0] == MODE_SPEED) ||
		(ctrl_r[1:0] == MODE_VOLTAGE));

	// Inrush period in cycles; 5 ms plus one step per code
	assign stepPeriod = 32'(INRUSH_BASE) +
		32'({16'h0, inrush_r} * 32'(INRUSH_STEP_CYC));

	assign runReq = (ctrl_r[CTRL_IN_A_BIT] | ctrl_r[CTRL_IN_B_BIT]) &
		(setpoint_r != 8'h00);
	assign dirReq = ctrl_r[CTRL_IN_B_BIT] & ~ctrl_r[CTRL_IN_A_BIT];

	// One level step per inrush period, so a full ramp takes
	// inrush period times setpoint
	assign stepTick = (stepCnt_r + 32'h1 >= stepPeriod);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stepCnt_r <= 32'h0;
		end else if ((state_r == ST_RAMP_UP ||
			state_r == ST_RAMP_DOWN) && !stepTick) begin
			stepCnt_r <= stepCnt_r + 32'h1;
		end else begin
			stepCnt_r <= 32'h0;
		end
	end

	// ------------------------------------------------------------------
	// Protection: overcurrent
	// ------------------------------------------------------------------
	// Any of the four FET limits counts toward the deglitch window
	assign ocAny  = |pinFilt_r[3:0] & (state_r != ST_IDLE);
	assign ocTrip = ocAny &
		(ocCnt_r == 8'(OC_DEGLITCH_CYC - 1));

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ocCnt_r <= 8'h0;
		end else if (ocAny && !ocTrip) begin
			ocCnt_r <= ocCnt_r + 8'h1;
		end else begin
			ocCnt_r <= 8'h0;
		end
	end

	// Retry timer restarts each trip, so the cycle repeats while the
	// short persists
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			retryCnt_r <= 32'h0;
		end else if (ocTrip && ctrl_r[CTRL_OCSEL_BIT]) begin
			retryCnt_r <= 32'(RETRY_CYC);
		end else if (retryCnt_r != 32'h0) begin
			retryCnt_r <= retryCnt_r - 32'h1;
		end
	end

	// Latch-off: only the clear command releases; a new trip wins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ocLatch_r <= 1'b0;
		end else begin
			ocLatch_r <= (ocTrip & ~ctrl_r[CTRL_OCSEL_BIT]) |
				(ocLatch_r & ~clrCmd);
		end
	end

	assign ocOff = ocLatch_r | (retryCnt_r != 32'h0);

	// ------------------------------------------------------------------
	// Protection: thermal and supply
	// ------------------------------------------------------------------
	// Latch holds after cool-down until cleared while cool
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			thLatch_r <= 1'b0;
		end else begin
			thLatch_r <= (tempHigh & ~ctrl_r[CTRL_THSEL_BIT]) |
				(thLatch_r & ~clrCmd);
		end
	end

	assign thOff = tempHigh | thLatch_r;

	// Core just out of reset: hold fault until supply is good
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			powerUp_r <= 1'b1;
		end else if (!vmLowNow) begin
			powerUp_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Flags: a set in the clearing cycle wins
	// ------------------------------------------------------------------
	assign faultNxt = ocTrip | ocOff | thOff | vmLowNow | powerUp_r;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ocFlag_r    <= 1'b0;
			thFlag_r    <= 1'b0;
			uvFlag_r    <= 1'b0;
			faultFlag_r <= 1'b0;
		end else begin
			ocFlag_r    <= ocTrip | (ocFlag_r & ~clrCmd);
			thFlag_r    <= tempHigh | (thFlag_r & ~clrCmd);
			uvFlag_r    <= (vmLowNow & ~powerUp_r) |
				(uvFlag_r & ~clrCmd);
			faultFlag_r <= faultNxt;
		end
	end

	// Open-drain fault pin: driven low only while a fault stands
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			faultPinNOut <= 1'b0;
			faultPinNOe  <= 1'b0;
		end else begin
			faultPinNOut <= 1'b0;
			faultPinNOe  <= faultNxt;
		end
	end

	// ------------------------------------------------------------------
	// Ramp sequencer
	// ------------------------------------------------------------------
	// Sleep is treated as a fault here so the bridge is released at once
	assign bridgeOff = faultNxt | sleepNow;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			level_r <= 8'h0;
			dir_r   <= 1'b0;
		end else if (bridgeOff) begin
			state_r <= ST_IDLE;
			level_r <= 8'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (runReq) begin
						dir_r <= dirReq;
						if (softActive) begin
							state_r <= ST_RAMP_UP;
							level_r <= 8'h0;
						end else begin
							state_r <= ST_RUN;
							level_r <= setpoint_r;
						end
					end
				end
				ST_RAMP_UP: begin
					if (!runReq || dirReq != dir_r) begin
						state_r <= ST_RAMP_DOWN;
					end else if (level_r >= setpoint_r) begin
						state_r <= ST_RUN;
						level_r <= setpoint_r;
					end else if (stepTick) begin
						level_r <= level_r + 8'h1;
					end
				end
				ST_RUN: begin
					if (!runReq || dirReq != dir_r) begin
						// Without soft ramp the bridge coasts at once
						state_r <= softActive ? ST_RAMP_DOWN : ST_IDLE;
						level_r <= softActive ? level_r : 8'h0;
					end else begin
						level_r <= setpoint_r;
					end
				end
				ST_RAMP_DOWN: begin
					if (level_r == 8'h0) begin
						// Reverse restarts soft; stop goes high-Z
						if (runReq) begin
							dir_r   <= dirReq;
							state_r <= ST_RAMP_UP;
						end else begin
							state_r <= ST_IDLE;
						end
					end else if (stepTick) begin
						level_r <= level_r - 8'h1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					level_r <= 8'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Stall blanking
	// ------------------------------------------------------------------
	// Loaded with one inrush period at each start from idle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			blankCnt_r <= 32'h0;
		end else if (state_r == ST_IDLE && runReq && !bridgeOff) begin
			blankCnt_r <= stepPeriod;
		end else if (blankCnt_r != 32'h0) begin
			blankCnt_r <= blankCnt_r - 32'h1;
		end
	end

	// ------------------------------------------------------------------
	// Bridge outputs
	// ------------------------------------------------------------------
	// Shared with bridgeHiZ so no brake closes while driving
	assign hiZNxt  = (state_r == ST_IDLE) | bridgeOff;
	assign brakeOn = ctrl_r[CTRL_OVPEN_BIT] & pinFilt_r[PIN_OUT_OVER] &
		(sleepNow | hiZNxt);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			driveLevel   <= 8'h0;
			bridgeEnable <= 1'b0;
			bridgeDir    <= 1'b0;
			bridgeHiZ    <= 1'b1;
			chargePumpEn <= 1'b0;
			stallBlank   <= 1'b0;
		end else begin
			driveLevel   <= level_r;
			bridgeEnable <= ~hiZNxt;
			bridgeDir    <= dir_r;
			bridgeHiZ    <= hiZNxt;
			chargePumpEn <= ~vmLowNow & ~sleepNow;
			stallBlank   <= (state_r == ST_RAMP_UP) |
				(blankCnt_r != 32'h0);
		end
	end

	// Generator braking; in sleep a braking overcurrent drops one side
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lowSideBrake <= 2'h0;
		end else begin
			lowSideBrake[0] <= brakeOn;
			lowSideBrake[1] <= brakeOn &
				~(sleepNow & pinFilt_r[PIN_BRAKE_OC]);
		end
	end

endmodule : mrfc_core

// ### verif/mrfc_core_chk.sv
// Port-level assertions for the motor ramp and fault control core
`timescale 1ns/1ps

module mrfc_core_chk
	import mrfc_pkg::*;
(
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  ocLimit,
	input wire logic        overTemp,
	input wire logic        vmLow,
	input wire logic        outOverSupply,
	input wire logic [14:0] targetSpeed,
	input wire logic        bridgeEnable,
	input wire logic        bridgeHiZ,
	input wire logic        chargePumpEn,
	input wire logic [1:0]  lowSideBrake,
	input wire logic        faultPinNOut,
	input wire logic        faultPinNOe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// Current-limit run length, saturating
	logic [7:0] ocRun_r;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			ocRun_r <= 8'h00;
		else if (ocLimit == 4'h0)
			ocRun_r <= 8'h00;
		else if (ocRun_r != 8'hFF)
			ocRun_r <= ocRun_r + 8'h01;
	end

	property p_scale;
		targetSpeed[3:0] == 4'h0;
	endproperty
	a_scale: assert property (p_scale)
		else $error("speed not x16");
	property p_answer;
		psel && penable && !pready |=> pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("late ready");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("long ready");
	property p_slverr;
		pslverr |-> pready && psel && penable;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("stray error");
	property p_uv;
		vmLow [*8] |-> bridgeHiZ && !chargePumpEn && faultPinNOe;
	endproperty
	a_uv: assert property (p_uv)
		else $error("no uv shutdown");
	property p_hot;
		overTemp [*8] |-> !bridgeEnable && faultPinNOe;
	endproperty
	a_hot: assert property (p_hot)
		else $error("no hot shutdown");
	property p_oc;
		ocRun_r == 8'h28 |-> !bridgeEnable && faultPinNOe;
	endproperty
	a_oc: assert property (p_oc)
		else $error("no oc trip");
	property p_brake;
		lowSideBrake == 2'h3 |-> bridgeHiZ;
	endproperty
	a_brake: assert property (p_brake)
		else $error("brake while driven");
	property p_nobrake;
		!outOverSupply [*8] |-> lowSideBrake == 2'h0;
	endproperty
	a_nobrake: assert property (p_nobrake)
		else $error("stray brake");
	property p_odrain;
		faultPinNOut == 1'b0;
	endproperty
	a_odrain: assert property (p_odrain)
		else $error("pin driven high");
endmodule : mrfc_core_chk

bind mrfc_core mrfc_core_chk u_mrfc_core_chk (.mclk(mclk), .nrst(nrst),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.ocLimit(ocLimit), .overTemp(overTemp), .vmLow(vmLow),
	.outOverSupply(outOverSupply), .targetSpeed(targetSpeed),
	.bridgeEnable(bridgeEnable), .bridgeHiZ(bridgeHiZ),
	.chargePumpEn(chargePumpEn), .lowSideBrake(lowSideBrake),
	.faultPinNOut(faultPinNOut), .faultPinNOe(faultPinNOe));

// ### verif/mrfc_host.sv
// Host controller model: register bus master of the core
`timescale 1ns/1ps

module mrfc_host
	import mrfc_pkg::*;
(
	input  wire logic        mclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready
);
	// Bus idle from time zero
	initial {psel, penable, pwrite, paddr, pwdata} = '0;

	// One transfer, held until ready is sampled
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output bit to);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		to = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : mrfc_host

// ### verif/tb.sv
// Self-checking bench for the motor ramp and fault control core
`timescale 1ns/1ps

module tb
	import mrfc_pkg::*;
;
	localparam int RC = 50;
	typedef struct {logic [31:0] d, m; logic e;} mrfc_exp_type;
	logic        mclk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, driveLevel, sp;
	logic [31:0] pwdata, prdata;
	logic [3:0]  ocLimit;
	logic        overTemp, vmLow, outOverSupply, brakeOverCur, sleepReq;
	logic [14:0] targetSpeed;
	logic        bridgeEnable, bridgeDir, bridgeHiZ, chargePumpEn;
	logic [1:0]  lowSideBrake;
	logic        stallBlank, faultPinNOut, faultPinNOe;
	int          err_total, compares, n, sd;
	mrfc_exp_type expQ[$], x;

	mrfc_core #(.INRUSH_BASE(20), .RETRY_CYC(RC)) u_mrfc_core (
		.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ocLimit(ocLimit),
		.overTemp(overTemp), .vmLow(vmLow), .outOverSupply(outOverSupply),
		.brakeOverCur(brakeOverCur), .sleepReq(sleepReq),
		.driveLevel(driveLevel), .targetSpeed(targetSpeed),
		.bridgeEnable(bridgeEnable), .bridgeDir(bridgeDir),
		.bridgeHiZ(bridgeHiZ), .chargePumpEn(chargePumpEn),
		.lowSideBrake(lowSideBrake), .stallBlank(stallBlank),
		.faultPinNOut(faultPinNOut), .faultPinNOe(faultPinNOe));
	mrfc_host u_mrfc_host (.mclk(mclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));

	always #50 mclk = ~mclk;

	task automatic fail(input string s);
		err_total++;
		$display("ERROR %0t %s", $time, s);
	endtask : fail
	task automatic chk(input bit ok, input string s);
		compares++;
		if (!ok) fail(s);
	endtask : chk
	task automatic wrap_up;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
	endtask : cyc
	// Note the answer, then run the transfer
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic e);
		bit to;
		expQ.push_back('{d & m, m, e});
		u_mrfc_host.xfer(w, a, d, to);
		if (to) begin
			fail("bus hang");
			wrap_up();
		end
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr
	task automatic st(input logic [31:0] v);
		acc(1'b0, ADDR_STATUS, v, 32'hF, 1'b0);
	endtask : st
	task automatic clr;
		wr(ADDR_CLEAR, 32'h1);
	endtask : clr
	function automatic logic [31:0] cv(input logic [1:0] md, input logic sf,
		input logic [1:0] sc, input logic [1:0] ab, input logic [1:0] rc);
		cv = 32'h0;
		cv[CTRL_MODE_LSB +: 2] = md;
		cv[CTRL_SOFT_BIT] = sf;
		cv[CTRL_SCALE_LSB +: 2] = sc;
		cv[CTRL_IN_A_BIT +: 2] = ab;
		cv[CTRL_OCSEL_BIT +: 2] = rc;
		cv[CTRL_OVPEN_BIT] = 1'b1;
	endfunction : cv
	task automatic run(input logic [1:0] rc);
		wr(ADDR_CTRL, cv(2'h0, 1'b0, 2'h0, 2'h1, rc));
		cyc(4);
	endtask : run
	// Bounded wait for a level; gives the cycles taken
	task automatic wlev(input logic [7:0] v, output int c);
		for (c = 0; driveLevel !== v && c < 3000; c++)
			@(posedge mclk);
		if (c >= 3000) begin
			fail("level wait");
			wrap_up();
		end
	endtask : wlev

	// Oldest note meets each bus answer
	always @(posedge mclk) begin
		if (pready === 1'b1) begin
			if (expQ.size() == 0)
				fail("stray answer");
			else begin
				x = expQ.pop_front();
				chk((prdata & x.m) === x.d && pslverr === x.e, "bus data");
			end
		end
	end

	initial begin
		{mclk, nrst, ocLimit, overTemp, outOverSupply} = 0;
		{brakeOverCur, sleepReq, err_total, compares} = 0;
		vmLow = 1'b1;
		sd = $urandom(1);
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		st(32'h1);
		vmLow <= 1'b0;
		cyc(10);
		st(32'h0);
		acc(1'b0, ADDR_CTRL, 32'h200, 32'h3FF, 1'b0);
		acc(1'b0, ADDR_INRUSH, {16'h0, INRUSH_RST}, '1, 1'b0);
		acc(1'b1, 8'h14, 32'hA5, 32'h0, 1'b1);
		acc(1'b0, 8'h14, 32'h0, '1, 1'b1);
		// Scale codes; soft bit ignored in modes 0 and 1
		for (int s = 0; s < 4; s++) begin
			sp = 8'($urandom_range(255, 1));
			wr(ADDR_SETPOINT, {24'h0, sp});
			wr(ADDR_CTRL, cv(2'(s) & 2'h1, 1'b1, 2'(s), 2'h1, 2'h0));
			cyc(8);
			chk(targetSpeed === 15'(sp) << (4 + s), "scale");
			chk(driveLevel === sp, "soft ignored");
		end
		// Soft start, reversal, setpoint stop, input stop
		wr(ADDR_CTRL, cv(2'h0, 1'b0, 2'h0, 2'h0, 2'h0));
		wr(ADDR_INRUSH, 32'h0);
		wr(ADDR_SETPOINT, 32'h4);
		wr(ADDR_CTRL, cv(MODE_SPEED, 1'b1, 2'h0, 2'h1, 2'h0));
		cyc(30);
		chk(driveLevel inside {[1:3]} && stallBlank === 1'b1, "up");
		wlev(8'h4, n);
		chk(n inside {[40:60]}, "ramp time");
		cyc(4);
		chk(!stallBlank, "blank end");
		wr(ADDR_CTRL, cv(MODE_VOLTAGE, 1'b1, 2'h0, 2'h2, 2'h0));
		wlev(8'h0, n);
		chk(n > 40, "reverse down");
		wlev(8'h4, n);
		chk(n > 40 && bridgeDir === 1'b1, "reverse up");
		wr(ADDR_SETPOINT, 32'h0);
		wlev(8'h0, n);
		chk(n > 40, "setpoint stop");
		wr(ADDR_SETPOINT, 32'h4);
		wlev(8'h4, n);
		wr(ADDR_CTRL, cv(MODE_SPEED, 1'b1, 2'h0, 2'h0, 2'h0));
		cyc(4);
		chk(!bridgeHiZ, "stop not coast");
		wlev(8'h0, n);
		cyc(4);
		chk(bridgeHiZ, "stop hiz");
		// Latched trip on each FET detector
		for (int i = 0; i < 4; i++) begin
			run(2'h0);
			ocLimit <= 4'h1 << i;
			cyc(45);
			chk(!bridgeEnable && faultPinNOe, "trip");
			ocLimit <= 4'h0;
			cyc(80);
			st(32'h3);
			chk(!bridgeEnable, "latched");
			clr;
			cyc(8);
			chk(bridgeEnable && !faultPinNOe, "resume");
		end
		run(2'h1);
		ocLimit <= 4'h4;
		cyc(45);
		chk(!bridgeEnable && faultPinNOe, "retry off");
		ocLimit <= 4'h0;
		cyc(RC + 10);
		chk(bridgeEnable && !faultPinNOe, "retry on");
		clr;
		// Thermal auto recovery, then latch-off
		run(2'h2);
		overTemp <= 1'b1;
		cyc(8);
		chk(!bridgeEnable && faultPinNOe, "hot");
		st(32'h5);
		overTemp <= 1'b0;
		cyc(8);
		st(32'h4);
		chk(bridgeEnable && !faultPinNOe, "cool");
		clr;
		run(2'h0);
		overTemp <= 1'b1;
		cyc(8);
		overTemp <= 1'b0;
		cyc(8);
		chk(!bridgeEnable, "hot latched");
		clr;
		cyc(8);
		chk(bridgeEnable, "hot cleared");
		// Supply dip above core reset
		vmLow <= 1'b1;
		cyc(8);
		chk(bridgeHiZ && !chargePumpEn && faultPinNOe, "uv");
		st(32'h9);
		vmLow <= 1'b0;
		cyc(8);
		st(32'h8);
		chk(bridgeEnable, "uv resume");
		clr;
		st(32'h0);
		// Overvoltage braking in high impedance and sleep
		wr(ADDR_CTRL, cv(2'h0, 1'b0, 2'h0, 2'h0, 2'h0));
		outOverSupply <= 1'b1;
		cyc(8);
		chk(lowSideBrake === 2'h3, "brake");
		sleepReq <= 1'b1;
		brakeOverCur <= 1'b1;
		cyc(8);
		chk(lowSideBrake !== 2'h3, "brake limit");
		{sleepReq, brakeOverCur} <= 2'h0;
		wr(ADDR_CTRL, 32'h0);
		cyc(8);
		chk(lowSideBrake === 2'h0, "brake off");
		wrap_up();
	end
endmodule : tb
